// *** verilog/sacc_ctrl.sv ***
// Purpose: Digital control of the primary_converter: trigger choice, result latch, window compare, interrupts.
// Assumes: The converter core, timers and register master share clk_sys_i.
// Notes: One conversion at a time; triggers arriving while busy or shut down are dropped.
//
// Notes on behaviour
// RULE1 - A conversion starts on the selected trigger: software, timer 2 overflow, timer 3 overflow or external pin.
// RULE2 - On completion the result is latched into a register pair, a done flag is set and an interrupt raised if enabled.
// RULE3 - The result sits right or left aligned in its pair as software selects.
// RULE4 - Each result is checked against a window and flags an interrupt when inside or outside, as configured.
// RULE5 - The channel selector offers nine inputs, eight external and one temperature sensor.
// RULE6 - Each adjacent pair of external channels is single-ended or differential on its own setting.
// RULE7 - The gain code selects one of six gains, 0.5, 1, 2, 4, 8 and 16.
// RULE8 - Software may shut the converter down, and no conversion starts while it is down.
// RULE9 - The reference is taken from the first_dac_output or from the external reference pin.
// RULE10 - The trigger source must not ask for conversions faster than 100 ksps.
// RULE11 - A software start is signalled out so the secondary_converter can start in step.
// RULE12 - The external start pin is synchronised and its rising edge is the trigger.
`include "sacc_defines.svh"

module sacc_ctrl
	import sacc_pkg::*;
#(
	parameter int RES_BITS = 12
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic tmr2_ovf_i,
	input wire logic tmr3_ovf_i,
	input wire logic ext_start_i,
	input wire logic conv_done_i,
	input wire logic [RES_BITS-1:0] conv_data_i,
	output logic conv_start_o,
	output logic sec_sync_start_o,
	output logic [3:0] chan_sel_o,
	output logic [3:0] pair_diff_o,
	output logic [2:0] gain_sel_o,
	output logic ref_ext_o,
	output logic shutdown_o,
	output logic irq_o
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] ctrl_reg;
	logic [3:0] chan_reg;
	logic [3:0] pair_reg;
	logic [2:0] gain_reg;
	logic ref_reg;
	logic [15:0] res_reg;
	logic [15:0] wlo_reg;
	logic [15:0] whi_reg;
	logic [1:0] stat_reg;
	logic [1:0] stat_next;
	logic [1:0] mask_reg;
	logic [7:0] rdata_reg;
	logic conv_start_reg;
	logic sec_sync_reg;
	sacc_state_e state_reg;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic wr_ctrl;
	logic wr_cmd;
	logic wr_chan;
	logic wr_pair;
	logic wr_gain;
	logic wr_wlo_hi;
	logic wr_wlo_lo;
	logic wr_whi_hi;
	logic wr_whi_lo;
	logic wr_stat;
	logic wr_mask;

	// Write strobes per register; unmapped writes fall through with no effect.
	assign wr_ctrl = reg_wr_i && (reg_addr_i == `SACC_OFS_CTRL);
	assign wr_cmd = reg_wr_i && (reg_addr_i == `SACC_OFS_CMD);
	assign wr_chan = reg_wr_i && (reg_addr_i == `SACC_OFS_CHAN);
	assign wr_pair = reg_wr_i && (reg_addr_i == `SACC_OFS_PAIR);
	assign wr_gain = reg_wr_i && (reg_addr_i == `SACC_OFS_GAIN);
	assign wr_wlo_hi = reg_wr_i && (reg_addr_i == `SACC_OFS_WLO_HI);
	assign wr_wlo_lo = reg_wr_i && (reg_addr_i == `SACC_OFS_WLO_LO);
	assign wr_whi_hi = reg_wr_i && (reg_addr_i == `SACC_OFS_WHI_HI);
	assign wr_whi_lo = reg_wr_i && (reg_addr_i == `SACC_OFS_WHI_LO);
	assign wr_stat = reg_wr_i && (reg_addr_i == `SACC_OFS_STAT);
	assign wr_mask = reg_wr_i && (reg_addr_i == `SACC_OFS_MASK);

	// ----------------------------------------
	// Trigger selection
	// ----------------------------------------
	logic ext_rise;
	logic sw_start;
	logic trig_hit;
	logic start_ok;
	sacc_trig_e trig_sel;

	sacc_start_sync u_start_sync (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.pin_i(ext_start_i),
		.rise_o(ext_rise)
	);

	// The trigger field picks exactly one source; the others are ignored entirely.
	assign trig_sel = sacc_trig_e'(ctrl_reg[`SACC_CTRL_TRIG_MSB:`SACC_CTRL_TRIG_LSB]);
	assign sw_start = wr_cmd && reg_wdata_i[`SACC_CMD_START] && (trig_sel == SACC_TRIG_SW);
	assign trig_hit = sw_start || // RULE1
		((trig_sel == SACC_TRIG_TMR2) && tmr2_ovf_i) ||
		((trig_sel == SACC_TRIG_TMR3) && tmr3_ovf_i) ||
		((trig_sel == SACC_TRIG_EXT) && ext_rise);
	// Back-to-back triggers beyond the converter rate are simply dropped while busy.
	assign start_ok = trig_hit && (state_reg == SACC_IDLE) && !ctrl_reg[`SACC_CTRL_SHDN]; // RULE8 RULE10

	// ----------------------------------------
	// Result shaping and window
	// ----------------------------------------
	logic [15:0] raw_word;
	logic [15:0] just_word;
	logic in_window;
	logic done_evt;
	logic win_evt;

	function automatic logic [15:0] sacc_justify(input logic [15:0] raw, input logic left);
		sacc_justify = left ? (raw << (16 - RES_BITS)) : raw;
	endfunction : sacc_justify

	// The window is checked on the right-aligned value so bounds do not depend on alignment.
	assign raw_word = 16'(conv_data_i);
	assign just_word = sacc_justify(raw_word, ctrl_reg[`SACC_CTRL_LJUST]); // RULE3
	assign in_window = (raw_word >= wlo_reg) && (raw_word <= whi_reg);
	assign done_evt = conv_done_i && (state_reg == SACC_BUSY);
	assign win_evt = done_evt && (in_window == ctrl_reg[`SACC_CTRL_WIN_IN]); // RULE4

	// Sticky flags: a new event beats a write-one-to-clear in the same cycle.
	always_comb begin
		stat_next = stat_reg;
		if (wr_stat) begin
			stat_next = stat_reg & ~reg_wdata_i[1:0];
		end
		if (done_evt) begin
			stat_next[`SACC_ST_DONE] = 1'b1; // RULE2
		end
		if (win_evt) begin
			stat_next[`SACC_ST_WIN] = 1'b1; // RULE4
		end
	end

	// ----------------------------------------
	// Conversion sequencer
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= SACC_IDLE;
		end else begin
			unique case (state_reg)
				SACC_IDLE: begin
					if (start_ok) begin
						state_reg <= SACC_BUSY;
					end
				end
				SACC_BUSY: begin
					if (conv_done_i) begin
						state_reg <= SACC_IDLE;
					end
				end
			endcase
		end
	end

	// Start pulses toward the core and the secondary_converter.
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			conv_start_reg <= 1'b0;
			sec_sync_reg <= 1'b0;
		end else begin
			conv_start_reg <= start_ok; // RULE1
			sec_sync_reg <= start_ok && sw_start; // RULE11
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_reg <= `SACC_CTRL_RST;
			chan_reg <= 4'h0;
			pair_reg <= 4'h0;
			gain_reg <= `SACC_GAIN_RST;
			ref_reg <= 1'b0;
			mask_reg <= 2'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= {3'h0, reg_wdata_i[4:0]}; // RULE8
			end
			// Channel codes above the temperature channel are refused.
			if (wr_chan && (reg_wdata_i[3:0] <= `SACC_CHAN_MAX)) begin
				chan_reg <= reg_wdata_i[3:0]; // RULE5
			end
			if (wr_pair) begin
				pair_reg <= reg_wdata_i[3:0]; // RULE6
			end
			// Gain codes six and seven have no meaning and leave the gain unchanged.
			if (wr_gain) begin
				ref_reg <= reg_wdata_i[`SACC_GAIN_REF]; // RULE9
				if (reg_wdata_i[2:0] <= `SACC_GAIN_MAX) begin
					gain_reg <= reg_wdata_i[2:0]; // RULE7
				end
			end
			if (wr_mask) begin
				mask_reg <= reg_wdata_i[1:0];
			end
		end
	end

	// Window bounds and latched result.
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wlo_reg <= 16'h0000;
			whi_reg <= `SACC_WHI_RST;
			res_reg <= 16'h0000;
		end else begin
			if (wr_wlo_hi) begin
				wlo_reg[15:8] <= reg_wdata_i;
			end
			if (wr_wlo_lo) begin
				wlo_reg[7:0] <= reg_wdata_i;
			end
			if (wr_whi_hi) begin
				whi_reg[15:8] <= reg_wdata_i;
			end
			if (wr_whi_lo) begin
				whi_reg[7:0] <= reg_wdata_i;
			end
			if (done_evt) begin
				res_reg <= just_word; // RULE2
			end
		end
	end

	// Status flags.
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stat_reg <= 2'h0;
		end else begin
			stat_reg <= stat_next;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [7:0] rd_mux;

	// Unmapped offsets read as zero; reads have no side effects.
	always_comb begin
		rd_mux = 8'h00;
		unique case (reg_addr_i)
			`SACC_OFS_CTRL: rd_mux = ctrl_reg;
			`SACC_OFS_CHAN: rd_mux = {4'h0, chan_reg};
			`SACC_OFS_PAIR: rd_mux = {4'h0, pair_reg};
			`SACC_OFS_GAIN: rd_mux = {4'h0, ref_reg, gain_reg};
			`SACC_OFS_RES_HI: rd_mux = res_reg[15:8];
			`SACC_OFS_RES_LO: rd_mux = res_reg[7:0];
			`SACC_OFS_WLO_HI: rd_mux = wlo_reg[15:8];
			`SACC_OFS_WLO_LO: rd_mux = wlo_reg[7:0];
			`SACC_OFS_WHI_HI: rd_mux = whi_reg[15:8];
			`SACC_OFS_WHI_LO: rd_mux = whi_reg[7:0];
			`SACC_OFS_STAT: rd_mux = {5'h00, (state_reg == SACC_BUSY), stat_reg};
			`SACC_OFS_MASK: rd_mux = {6'h00, mask_reg};
			default: rd_mux = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the read strobe.
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= reg_rd_i ? rd_mux : 8'h00;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata_o = rdata_reg;
	assign conv_start_o = conv_start_reg;
	assign sec_sync_start_o = sec_sync_reg;
	assign chan_sel_o = chan_reg;
	assign pair_diff_o = pair_reg;
	assign gain_sel_o = gain_reg;
	assign ref_ext_o = ref_reg;
	assign shutdown_o = ctrl_reg[`SACC_CTRL_SHDN];
	assign irq_o = |(stat_reg & mask_reg); // RULE2 RULE4

endmodule : sacc_ctrl

// *** verilog/sacc_defines.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the converter control block.
// Assumes: An eight-bit register port with byte-wide offsets.
// Notes: Definitions only.
`ifndef SACC_DEFINES_SVH
`define SACC_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SACC_OFS_CTRL 8'h00
`define SACC_OFS_CMD 8'h01
`define SACC_OFS_CHAN 8'h02
`define SACC_OFS_PAIR 8'h03
`define SACC_OFS_GAIN 8'h04
`define SACC_OFS_RES_HI 8'h05
`define SACC_OFS_RES_LO 8'h06
`define SACC_OFS_WLO_HI 8'h07
`define SACC_OFS_WLO_LO 8'h08
`define SACC_OFS_WHI_HI 8'h09
`define SACC_OFS_WHI_LO 8'h0A
`define SACC_OFS_STAT 8'h0B
`define SACC_OFS_MASK 8'h0C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SACC_CTRL_SHDN 0
`define SACC_CTRL_TRIG_LSB 1
`define SACC_CTRL_TRIG_MSB 2
`define SACC_CTRL_LJUST 3
`define SACC_CTRL_WIN_IN 4
`define SACC_CMD_START 0
`define SACC_GAIN_REF 3
`define SACC_ST_DONE 0
`define SACC_ST_WIN 1
`define SACC_ST_BUSY 2

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define SACC_CTRL_RST 8'h01
`define SACC_GAIN_RST 3'h1
`define SACC_GAIN_MAX 3'h5
`define SACC_CHAN_MAX 4'h8
`define SACC_WHI_RST 16'hFFFF

// ----------------------------------------
// Timing
// ----------------------------------------
`define SACC_CLK_HZ 200000000
`define SACC_MAX_SPS 100000
`define SACC_MIN_GAP_CYC (`SACC_CLK_HZ / `SACC_MAX_SPS)

`endif

// *** verilog/sacc_pkg.sv ***
// Purpose: Types shared by the converter control block.
// Assumes: Nothing beyond the defines header.
// Notes: Trigger codes follow the two trigger bits of the control register.
package sacc_pkg;

	typedef enum logic [1:0] {
		SACC_TRIG_SW,
		SACC_TRIG_TMR2,
		SACC_TRIG_TMR3,
		SACC_TRIG_EXT
	} sacc_trig_e;

	typedef enum logic {
		SACC_IDLE,
		SACC_BUSY
	} sacc_state_e;

endpackage : sacc_pkg

// *** verilog/sacc_start_sync.sv ***
// Purpose: Brings the external start pin into the system clock and flags its rising edge.
// Assumes: The pin is asynchronous to clk_sys_i.
// Notes: A change counts once the second and third stages agree.
module sacc_start_sync (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic pin_i,
	output logic rise_o
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic level_reg;
	logic agree;

	// Only s2 and s3 are compared; s1 feeds s2 alone to keep metastability contained.
	assign agree = (s2_reg == s3_reg);
	assign rise_o = agree && s3_reg && !level_reg; // RULE12

	// Three-stage chain plus the filtered level.
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level_reg <= 1'b0;
		end else begin
			s1_reg <= pin_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (agree) begin
				level_reg <= s3_reg; // RULE12
			end
		end
	end

endmodule : sacc_start_sync

// *** test/sacc_core_model.sv ***
// Purpose: Converter core stand-in that answers each start with a done pulse and a result.
// Assumes: Starts arrive no closer than one conversion time.
// Notes: Outside the done pulse the data lines carry the inverse of the result.
module sacc_core_model #(
	parameter int LAT = 20
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic start_i,
	input wire logic [11:0] val_i,
	output logic done_o,
	output logic [11:0] data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	// --------------------------------
	// Conversion timer
	// --------------------------------
	// A fixed latency of LAT cycles lets conversions run far faster than the throughput ceiling.
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt <= 0;
		end else if (start_i) begin
			cnt <= LAT;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
	assign done_o = (cnt == 1);
	// Released data lines must not look like a stale valid result.
	assign data_o = done_o ? val_i : ~val_i;
endmodule : sacc_core_model

// *** test/sacc_ctrl_checker.sv ***
// Purpose: Port-level assertions for the converter control block.
// Assumes: Core latency of the bench is well above eight cycles.
// Notes: Bound into every instance of the control block.
`include "sacc_defines.svh"
module sacc_ctrl_checker (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic tmr2_ovf_i,
	input wire logic tmr3_ovf_i,
	input wire logic ext_start_i,
	input wire logic conv_done_i,
	input wire logic conv_start_o,
	input wire logic sec_sync_start_o,
	input wire logic [3:0] chan_sel_o,
	input wire logic [2:0] gain_sel_o,
	input wire logic shutdown_o,
	input wire logic irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	// --------------------------------
	// Assertions
	// --------------------------------
	chk_start_cause: assert property (conv_start_o |-> $past(reg_wr_i) || $past(tmr2_ovf_i)
		|| $past(tmr3_ovf_i) || $past(ext_start_i, 3)) else $error("start without a trigger");
	chk_start_single: assert property (conv_start_o |=> !conv_start_o [*8])
		else $error("second start during a conversion");
	chk_sync_start: assert property (sec_sync_start_o |-> conv_start_o && $past(reg_wr_i))
		else $error("sync start without software start");
	chk_down_idle: assert property ($past(shutdown_o) |-> !conv_start_o)
		else $error("start while shut down");
	chk_gain_code: assert property (gain_sel_o <= `SACC_GAIN_MAX)
		else $error("gain code out of range");
	chk_chan_code: assert property (chan_sel_o <= `SACC_CHAN_MAX)
		else $error("channel out of range");
	chk_irq_cause: assert property ($rose(irq_o) |-> $past(conv_done_i) || $past(reg_wr_i))
		else $error("interrupt without completion");
	chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data outside its cycle");
	cov_sync: cover property (conv_start_o && sec_sync_start_o);
	cov_irq: cover property ($rose(irq_o));
	cov_done: cover property (conv_done_i);
endmodule : sacc_ctrl_checker
bind sacc_ctrl sacc_ctrl_checker u_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tmr2_ovf_i(tmr2_ovf_i), .tmr3_ovf_i(tmr3_ovf_i),
	.ext_start_i(ext_start_i), .conv_done_i(conv_done_i), .conv_start_o(conv_start_o),
	.sec_sync_start_o(sec_sync_start_o), .chan_sel_o(chan_sel_o), .gain_sel_o(gain_sel_o),
	.shutdown_o(shutdown_o), .irq_o(irq_o));

// *** test/tb_top.sv ***
// Purpose: Self-checking bench for the converter control block.
// Assumes: Default twelve-bit results.
// Notes: Expected values come from the register layout and the window bounds set here.
`include "sacc_defines.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 0, nrst_i = 0, wr = 0, rd = 0, t2 = 0, t3 = 0, ext = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic done, start, sync, shdn, refx, irq;
	logic [11:0] val = 12'h000, data;
	logic [3:0] chan, pair;
	logic [2:0] gain;
	int num_errors = 0, cmp_count = 0, cyc = 0;
	// Ordered so the window flag is set in both modes and left clear at the inclusive bound.
	logic [11:0] raws [4] = '{12'h0A5, 12'h150, 12'h200, 12'h201};
	sacc_ctrl uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .tmr2_ovf_i(t2), .tmr3_ovf_i(t3),
		.ext_start_i(ext), .conv_done_i(done), .conv_data_i(data), .conv_start_o(start),
		.sec_sync_start_o(sync), .chan_sel_o(chan), .pair_diff_o(pair), .gain_sel_o(gain),
		.ref_ext_o(refx), .shutdown_o(shdn), .irq_o(irq));
	sacc_core_model core (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .start_i(start), .val_i(val),
		.done_o(done), .data_o(data));
	initial begin
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	// --------------------------------
	// Tasks
	// --------------------------------
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		@(posedge clk_sys_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys_i);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(logic [7:0] a, logic [7:0] exp);
		@(posedge clk_sys_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys_i);
		rd <= 1'b0;
		@(negedge clk_sys_i);
		chk(16'(rdata), 16'(exp));
	endtask : rd_reg
	// Fires trigger kind t and waits a bounded time for the start pulse.
	task automatic run(int t);
		int n;
		case (t)
			0: wr_reg(`SACC_OFS_CMD, 8'h01);
			1: begin @(posedge clk_sys_i); t2 <= 1'b1; @(posedge clk_sys_i); t2 <= 1'b0; end
			2: begin @(posedge clk_sys_i); t3 <= 1'b1; @(posedge clk_sys_i); t3 <= 1'b0; end
			default: begin @(posedge clk_sys_i); ext <= 1'b1; end
		endcase
		for (n = 0; n < 12 && start !== 1'b1; n++) @(negedge clk_sys_i);
		chk(16'(n < 12), 16'h0001);
		chk(16'(sync), 16'(t == 0));
		repeat (30) @(posedge clk_sys_i);
		ext <= 1'b0;
	endtask : run
	// --------------------------------
	// Timeout and main sequence
	// --------------------------------
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			conclude();
		end
	end
	initial begin
		logic [11:0] r;
		logic win;
		repeat (8) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		rd_reg(`SACC_OFS_CTRL, 8'h01);
		rd_reg(`SACC_OFS_GAIN, 8'h01);
		rd_reg(`SACC_OFS_WHI_HI, 8'hFF);
		chk(16'({shdn, gain}), 16'h0009);
		wr_reg(`SACC_OFS_CMD, 8'h01);
		repeat (30) @(posedge clk_sys_i);
		rd_reg(`SACC_OFS_STAT, 8'h00);
		wr_reg(`SACC_OFS_MASK, 8'h03);
		wr_reg(`SACC_OFS_WLO_HI, 8'h01);
		wr_reg(`SACC_OFS_WHI_HI, 8'h02);
		wr_reg(`SACC_OFS_WHI_LO, 8'h00);
		for (int t = 0; t < 4; t++) begin
			r = raws[t];
			val <= r;
			wr_reg(`SACC_OFS_CTRL, 8'(t % 2 * 16 + t / 2 * 8 + t * 2));
			run(t);
			win = (r >= 12'h100 && r <= 12'h200) ~^ (t % 2 == 1);
			rd_reg(`SACC_OFS_RES_HI, t / 2 ? r[11:4] : 8'(r[11:8]));
			rd_reg(`SACC_OFS_RES_LO, t / 2 ? {r[3:0], 4'h0} : r[7:0]);
			rd_reg(`SACC_OFS_STAT, {6'h00, win, 1'b1});
			chk(16'(irq), 16'h0001);
			wr_reg(`SACC_OFS_STAT, 8'h03);
			@(negedge clk_sys_i);
			chk(16'(irq), 16'h0000);
		end
		wr_reg(`SACC_OFS_MASK, 8'h00);
		// The loop left the pin trigger selected; a software start needs the software source again.
		wr_reg(`SACC_OFS_CTRL, 8'h00);
		run(0);
		chk(16'(irq), 16'h0000);
		chk(16'(shdn), 16'h0000);
		rd_reg(`SACC_OFS_STAT, 8'h03);
		wr_reg(`SACC_OFS_CHAN, 8'h08);
		wr_reg(`SACC_OFS_CHAN, 8'h09);
		wr_reg(`SACC_OFS_PAIR, 8'h0A);
		@(negedge clk_sys_i);
		chk(16'({chan, pair}), 16'h008A);
		for (int g = 0; g < 7; g++) begin
			wr_reg(`SACC_OFS_GAIN, 8'(g + (g % 2) * 8));
			@(negedge clk_sys_i);
			chk(16'({refx, gain}), 16'((g % 2) * 8 + (g < 6 ? g : 5)));
		end
		rd_reg(8'h20, 8'h00);
		conclude();
	end
endmodule : tb_top
